// [verilog/sie_pkg.sv]
// package: register map, field layout and reset values of the switch interrupt enables
package sie_pkg;
	localparam int unsigned SIE_NUM_IN    = 12;
	localparam int unsigned SIE_FIRST_IN  = 12;
	localparam int unsigned SIE_NUM_GEV   = 8;
	localparam int unsigned SIE_REG_W     = 24;
	// printed offsets are not all multiples of four: kept as indices
	localparam logic [7:0]  SIE_IDX_LOWER_SEL  = 8'h22;
	localparam logic [7:0]  SIE_IDX_UPPER_SEL  = 8'h23;
	localparam logic [7:0]  SIE_IDX_GLOBAL_EN  = 8'h24;
	localparam logic [7:0]  SIE_IDX_STATUS     = 8'h25;
	localparam logic [7:0]  SIE_IDX_MASK       = 8'h26;
	localparam logic [23:0] SIE_SEL_RESET      = 24'h000000;
	localparam logic [7:0]  SIE_GEV_RESET      = 8'h00;
	localparam logic [1:0]  SIE_CODE_OFF       = 2'h0;
	localparam logic [1:0]  SIE_CODE_RISE      = 2'h1;
	localparam logic [1:0]  SIE_CODE_FALL      = 2'h2;
	localparam logic [1:0]  SIE_CODE_BOTH      = 2'h3;
	localparam int unsigned SIE_GEV_CHECKSUM   = 7;
	localparam int unsigned SIE_GEV_SERIAL     = 0;
	localparam int unsigned SIE_GROUP_SIZE     = 4;
	// status/mask layout: bits 11-0 inputs 12-23, bits 19-12 global events
	localparam int unsigned SIE_STAT_W         = 20;
	localparam logic [19:0] SIE_STAT_RESET     = 20'h00000;
	localparam logic [19:0] SIE_MASK_RESET     = 20'h00000;

	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [9:0] waddr;
		logic [31:0] pwdata;
	} sie_apb_req_t;

	function automatic logic [9:0] sie_byte_addr(input logic [7:0] idx);
		sie_byte_addr = {idx, 2'b00};
	endfunction : sie_byte_addr
endpackage : sie_pkg

// [verilog/sie_edge_if.sv]
// interface: comparator samples and edge-select fields into the edge detector
`timescale 1ns/10ps
`default_nettype none
interface sie_edge_if;
	import sie_pkg::*;
	logic [SIE_NUM_IN-1:0]   comp_sample;
	logic [2*SIE_NUM_IN-1:0] edge_sel;
	logic [SIE_NUM_IN-1:0]   edge_hit;
	modport ctrl (output comp_sample, output edge_sel, input edge_hit);
	modport det  (input comp_sample, input edge_sel, output edge_hit);
endinterface : sie_edge_if
`default_nettype wire

// [verilog/sie_edge_detect.sv]
// edge detector: per-input crossing detection against the stored previous sample
`timescale 1ns/10ps
`default_nettype none
module sie_edge_detect
	import sie_pkg::*;
(
	input  wire logic i_clock,
	input  wire logic i_rst,
	sie_edge_if.det   edge_port
);
	logic [SIE_NUM_IN-1:0] prev_sample;
	logic [SIE_NUM_IN-1:0] rise;
	logic [SIE_NUM_IN-1:0] fall;

	// previous sample held to compare against the current one
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			prev_sample <= '0;
		end else begin
			prev_sample <= edge_port.comp_sample;
		end
	end

	assign rise = edge_port.comp_sample & ~prev_sample;
	assign fall = ~edge_port.comp_sample & prev_sample;

	genvar g;
	generate
		for (g = 0; g < SIE_NUM_IN; g++) begin : g_in
			wire logic [1:0] code = edge_port.edge_sel[2*g +: 2];
			// code bit 0 enables rising, bit 1 falling; code 3 gives both
			assign edge_port.edge_hit[g] =
				(code[0] & rise[g]) |
				(code[1] & fall[g]);
		end
	endgenerate
endmodule : sie_edge_detect
`default_nettype wire

// [verilog/sie_irq_enables.sv]
// top: APB register file, edge and global event interrupt gating
`timescale 1ns/10ps
`default_nettype none
module sie_irq_enables
	import sie_pkg::*;
(
	input  wire logic                   i_clock,
	input  wire logic                   i_rst,
	input  wire logic                   i_psel,
	input  wire logic                   i_penable,
	input  wire logic                   i_pwrite,
	input  wire logic [11:0]            i_paddr,
	input  wire logic [31:0]            i_pwdata,
	output logic      [31:0]            o_prdata,
	output logic                        o_pready,
	output logic                        o_pslverr,
	input  wire logic [SIE_NUM_IN-1:0]  i_comp_above,
	input  wire logic [SIE_NUM_GEV-1:0] i_global_event,
	output logic                        o_irq_n,
	output logic                        o_irq
);
	logic [SIE_NUM_IN-1:0]   comp_meta;
	logic [SIE_NUM_IN-1:0]   comp_sync;
	logic [SIE_NUM_GEV-1:0]  gev_meta;
	logic [SIE_NUM_GEV-1:0]  gev_sync;
	logic [SIE_NUM_GEV-1:0]  gev_prev;
	logic [SIE_REG_W-1:0]    lower_inputs_edge_irq_select;
	logic [SIE_REG_W-1:0]    upper_inputs_edge_irq_select;
	logic [SIE_NUM_GEV-1:0]  global_event_irq_enable;
	logic [SIE_STAT_W-1:0]   irq_status;
	logic [SIE_STAT_W-1:0]   irq_mask;
	logic [SIE_STAT_W-1:0]   next_irq_status;
	logic [SIE_STAT_W-1:0]   event_set;
	logic [SIE_NUM_GEV-1:0]  gev_rise;
	logic [31:0]             next_prdata;
	logic                    next_irq;
	logic [2:0]              settle;

	// events ignored until the sync pipe has refilled, so a pin already
	// high at reset release is not taken for an edge
	wire logic armed = settle[2];

	wire logic access = i_psel & i_penable & ~o_pready;
	wire logic wr     = access & i_pwrite;
	wire logic rd     = access & ~i_pwrite;
	wire logic aligned   = (i_paddr[1:0] == 2'b00);
	wire logic [9:0] wa  = i_paddr[11:2];
	wire logic hit_lower = aligned & (wa == {2'b00, SIE_IDX_LOWER_SEL});
	wire logic hit_upper = aligned & (wa == {2'b00, SIE_IDX_UPPER_SEL});
	wire logic hit_gen   = aligned & (wa == {2'b00, SIE_IDX_GLOBAL_EN});
	wire logic hit_stat  = aligned & (wa == {2'b00, SIE_IDX_STATUS});
	wire logic hit_mask  = aligned & (wa == {2'b00, SIE_IDX_MASK});
	wire logic hit_any   = hit_lower | hit_upper | hit_gen | hit_stat | hit_mask;

	sie_edge_if edge_bus ();

	assign edge_bus.comp_sample = comp_sync;
	assign edge_bus.edge_sel    = upper_inputs_edge_irq_select;

	// one comparator result per input; group thresholds are applied upstream
	sie_edge_detect u_edge (
		.i_clock   (i_clock),
		.i_rst     (i_rst),
		.edge_port (edge_bus.det)
	);

	// pin inputs pass two flip-flops before any logic looks at them
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			comp_meta <= '0;
			comp_sync <= '0;
			gev_meta  <= '0;
			gev_sync  <= '0;
			gev_prev  <= '0;
			settle    <= '0;
		end else begin
			comp_meta <= i_comp_above;
			comp_sync <= comp_meta;
			gev_meta  <= i_global_event;
			gev_sync  <= gev_meta;
			gev_prev  <= gev_sync;
			settle    <= {settle[1:0], 1'b1};
		end
	end

	// a disabled global event never reaches the status, hence never the pin
	assign gev_rise  = gev_sync & ~gev_prev & global_event_irq_enable;
	assign event_set = {gev_rise, edge_bus.edge_hit}
		& {SIE_STAT_W{armed}};

	// set wins over write-one-to-clear so no event is lost
	assign next_irq_status = wr & hit_stat
		? ((irq_status & ~i_pwdata[SIE_STAT_W-1:0]) | event_set)
		: (irq_status | event_set);

	assign next_irq = |(next_irq_status & ~irq_mask);

	always_comb begin
		next_prdata = 32'h00000000;
		if (hit_lower) begin
			next_prdata[SIE_REG_W-1:0] = lower_inputs_edge_irq_select;
		end else if (hit_upper) begin
			next_prdata[SIE_REG_W-1:0] = upper_inputs_edge_irq_select;
		end else if (hit_gen) begin
			next_prdata[SIE_NUM_GEV-1:0] = global_event_irq_enable;
		end else if (hit_stat) begin
			next_prdata[SIE_STAT_W-1:0] = irq_status;
		end else if (hit_mask) begin
			next_prdata[SIE_STAT_W-1:0] = irq_mask;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			lower_inputs_edge_irq_select <= SIE_SEL_RESET;
			upper_inputs_edge_irq_select <= SIE_SEL_RESET;
			global_event_irq_enable      <= SIE_GEV_RESET;
			irq_mask                     <= SIE_MASK_RESET;
		end else if (wr) begin
			if (hit_lower) begin
				lower_inputs_edge_irq_select <= i_pwdata[SIE_REG_W-1:0];
			end
			if (hit_upper) begin
				upper_inputs_edge_irq_select <= i_pwdata[SIE_REG_W-1:0];
			end
			if (hit_gen) begin
				// reserved bits 23-8 are not stored and read zero
				global_event_irq_enable <= i_pwdata[SIE_NUM_GEV-1:0];
			end
			if (hit_mask) begin
				irq_mask <= i_pwdata[SIE_STAT_W-1:0];
			end
		end
	end

	// mask bit one blocks that status bit from the pin
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			irq_status <= SIE_STAT_RESET;
			o_irq      <= 1'b0;
			o_irq_n    <= 1'b1;
		end else begin
			irq_status <= next_irq_status;
			o_irq      <= next_irq;
			o_irq_n    <= ~next_irq;
		end
	end

	// one wait state: pready is high in the second access cycle
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h00000000;
		end else begin
			o_pready  <= access;
			o_pslverr <= access & ~hit_any;
			o_prdata  <= rd ? next_prdata : 32'h00000000;
		end
	end
endmodule : sie_irq_enables
`default_nettype wire

// [tb/sie_irq_props.sv]
// checker: apb timing, read data and interrupt pin relations
`timescale 1ns/10ps
`default_nettype none
module sie_irq_props (
	input wire logic        i_clock,
	input wire logic        i_rst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        o_irq_n,
	input wire logic        o_irq
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	rdy_one_shot_a: assert property (o_pready |=> !o_pready)
		else $error("pready held longer than one cycle");
	rdy_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
		else $error("pready not one cycle after access");
	rdy_cause_a: assert property (o_pready |-> $past(i_psel && i_penable))
		else $error("pready without access");
	rd_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
		else $error("read data outside answer cycle");
	err_align_a: assert property (o_pready && i_paddr[1:0] != 2'h0 |-> o_pslverr)
		else $error("misaligned access not refused");
	gev_resv_a: assert property (o_pready && !i_pwrite && i_paddr == 12'h090
		|-> o_prdata[31:8] == 24'h0) else $error("reserved enable bits set");
	sel_width_a: assert property (o_pready && !i_pwrite && i_paddr == 12'h08c
		|-> o_prdata[31:24] == 8'h0) else $error("select above bit 23 set");
	irq_pair_a: assert property (o_irq_n != o_irq)
		else $error("interrupt pin copies disagree");
	irq_rst_a: assert property ($past(i_rst) |-> o_irq_n)
		else $error("interrupt asserted after reset");
endmodule : sie_irq_props
bind sie_irq_enables sie_irq_props i_props (.*);
`default_nettype wire

// [tb/sie_host_model.sv]
// host model: apb master side facing the interrupt enable block
`timescale 1ns/10ps
`default_nettype none
module sie_host_model (
	input  wire logic        i_clock,
	input  wire logic        i_pready,
	output logic             o_psel,
	output logic             o_penable,
	output logic             o_pwrite,
	output logic      [11:0] o_paddr,
	output logic      [31:0] o_pwdata
);
	initial {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} = '0;
	// request held until pready edge, so any wait count is tolerated
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge i_clock);
		{o_psel, o_pwrite, o_paddr, o_pwdata} <= {1'b1, w, a, d};
		@(posedge i_clock);
		o_penable <= 1'b1;
		@(posedge i_clock);
		while (i_pready !== 1'b1) @(posedge i_clock);
		{o_psel, o_penable} <= 2'b00;
	endtask : xfer
endmodule : sie_host_model
`default_nettype wire

// [tb/testbench.sv]
// testbench: register, edge select and global event interrupt checks
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        i_clock, i_rst, psel, penable, pwrite, o_pready, o_pslverr;
	logic        o_irq_n, o_irq, hit;
	logic [11:0] paddr, i_comp_above;
	logic [31:0] pwdata, o_prdata, d;
	logic [7:0]  i_global_event;
	logic [33:0] ent, exp_q[$];
	int          n_mismatch, tests_run, cycles, k;
	integer      seed = 32'h7338;
	sie_irq_enables i_sie_irq_enables (.i_clock(i_clock), .i_rst(i_rst),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_comp_above(i_comp_above), .i_global_event(i_global_event),
		.o_irq_n(o_irq_n), .o_irq(o_irq));
	sie_host_model i_host (.i_clock(i_clock), .i_pready(o_pready),
		.o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
		.o_paddr(paddr), .o_pwdata(pwdata));
	initial begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end
	task automatic finish_test;
		if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test
	task automatic check(input string nm, input logic [31:0] seen, ex);
		tests_run++;
		if (seen !== ex) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, seen);
		end
	endtask : check
	// e holds {slverr, read data}; writes check only slverr
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [31:0] dw, input logic [32:0] e);
		exp_q.push_back({~w, e});
		i_host.xfer(w, a, dw);
	endtask : acc
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			finish_test();
		end
		if (o_pready === 1'b1 && exp_q.size() > 0) begin
			ent = exp_q.pop_front();
			check("pslverr", {31'h0, o_pslverr}, {31'h0, ent[32]});
			if (ent[33]) check("prdata", o_prdata, ent[31:0]);
		end
	end
	initial begin
		{i_rst, i_comp_above, i_global_event} = {1'b1, 20'h0};
		repeat (4) @(posedge i_clock);
		i_rst <= 1'b0;
		for (int i = 0; i < 5; i++)
			acc(1'b0, 12'h088 + 12'(4 * i), 32'h0, 33'h0);
		d = $random(seed);
		acc(1'b1, 12'h08c, d, 33'h0);
		acc(1'b0, 12'h08c, 32'h0, {9'h0, d[23:0]});
		acc(1'b1, 12'h088, ~d, 33'h0);
		acc(1'b0, 12'h088, 32'h0, {9'h0, ~d[23:0]});
		acc(1'b1, 12'h090, 32'hffffffff, 33'h0);
		acc(1'b0, 12'h090, 32'h0, 33'h0ff);
		acc(1'b0, 12'h0fc, 32'h0, {1'b1, 32'h0});
		acc(1'b1, 12'h08d, d, {1'b1, 32'h0});
		for (int c = 0; c < 4; c++) begin
			k = 3 * c;
			acc(1'b1, 12'h08c, 32'(c) << (2 * k), 33'h0);
			for (int p = 1; p >= 0; p--) begin
				i_comp_above[k] <= p[0];
				hit = p[0] ? c[0] : c[1];
				repeat (8) @(posedge i_clock);
				check("irq_n", {31'h0, o_irq_n}, {31'h0, !hit});
				check("irq", {31'h0, o_irq}, {31'h0, hit});
				acc(1'b0, 12'h094, 32'h0, {1'b0, 32'(hit) << k});
				acc(1'b1, 12'h094, 32'hfffff, 33'h0);
			end
		end
		acc(1'b1, 12'h090, 32'h80, 33'h0);
		i_global_event <= 8'($random(seed)) | 8'h80;
		repeat (8) @(posedge i_clock);
		acc(1'b0, 12'h094, 32'h0, 33'h80000);
		for (int m = 0; m < 3; m++) begin
			acc(1'b1, m == 2 ? 12'h094 : 12'h098, m == 1 ? 0 : 32'hfffff, 0);
			repeat (2) @(posedge i_clock);
			check("irq_n", {31'h0, o_irq_n}, {31'h0, m != 1});
			check("irq", {31'h0, o_irq}, {31'h0, m == 1});
		end
		finish_test();
	end
endmodule : testbench
`default_nettype wire
